// ===== hw/cfg3_pkg.sv
package cfg3_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] CFG3_INDEX = 8'hC3;
  localparam logic [7:0] STATUS_INDEX = 8'hC4;
  localparam logic [7:0] CFG3_RESET = 8'h00;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_SER_TOP = 7;
  localparam int BIT_SER_23 = 6;
  localparam int BIT_SER_12 = 5;
  localparam int BIT_MAP_EN = 4;
  localparam int BIT_SUSPEND_REQUEST_N_EN = 3;
  localparam int BIT_SPARE = 2;
  localparam int BIT_NMI_EN = 1;
  localparam int BIT_LOCK = 0;
  // Bits that the lock protects outside management mode
  localparam logic [7:0] LOCK_MASK = 8'h0B;
  // Bits that software may store
  localparam logic [7:0] WRITABLE_MASK = 8'hFB;
  // ****************************************
  // Address quarters
  // ****************************************
  localparam logic [1:0] Q_TOP = 2'h3;
  localparam logic [1:0] Q_23 = 2'h2;
  localparam logic [1:0] Q_12 = 2'h1;
  // ****************************************
  // Indexes open while the map is closed
  // ****************************************
  localparam logic [7:0] OPEN_A_LO = 8'hC1;
  localparam logic [7:0] OPEN_A_HI = 8'hC3;
  localparam logic [7:0] OPEN_B_LO = 8'hCD;
  localparam logic [7:0] OPEN_B_HI = 8'hCF;
  localparam logic [7:0] OPEN_C_LO = 8'hFE;
  localparam logic [7:0] OPEN_C_HI = 8'hFF;
endpackage

// ===== hw/index_gate.sv
`timescale 1ns/10ps
module index_gate (
  input wire logic [7:0] index,
  input wire logic map_en,
  output logic allowed
);
  // ****************************************
  // Index filter for the configuration path
  // ****************************************
  always_comb begin
    allowed = map_en;
    if ((index >= cfg3_pkg::OPEN_A_LO && index <= cfg3_pkg::OPEN_A_HI) ||
        (index >= cfg3_pkg::OPEN_B_LO && index <= cfg3_pkg::OPEN_B_HI) ||
        (index >= cfg3_pkg::OPEN_C_LO && index <= cfg3_pkg::OPEN_C_HI)) begin
      allowed = 1'b1;
    end
  end
endmodule

// ===== hw/mgmt_mode_config_control.sv
`timescale 1ns/10ps
// Contract
// - Top bit orders top address quarter
// - Bit 6 orders 2GB-3GB quarter
// - Bit 5 orders 1GB-2GB quarter
// - Map enable opens every configuration index
// - Map closed: only few indexes open
// - Bit 3 passes suspend in management mode
// - Bit 1 passes NMI in management mode
// - NMI enable write needs unlock or mode
// - Reset clears the whole register
// - Extended indexes other than C1-C3, CD-CF, FE-FF need map enable set
module mgmt_mode_config_control (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic system_management_mode,
  input wire logic suspend_request_n,
  input wire logic nmi_request,
  input wire logic [31:0] access_addr,
  input wire logic [7:0] ext_index,
  output logic [7:0] config_control_three,
  output logic ordered_access,
  output logic ext_index_allowed,
  output logic suspend_taken,
  output logic nmi_taken
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [2:0] pin_s1_r;
  logic [2:0] pin_s1_nxt;
  logic [2:0] pin_s2_r;
  logic [2:0] pin_s2_nxt;
  logic [7:0] cfg_r;
  logic [7:0] cfg_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic ordered_r;
  logic ordered_nxt;
  logic allowed_r;
  logic allowed_nxt;
  logic suspend_request_n_r;
  logic suspend_request_n_nxt;
  logic nmi_r;
  logic nmi_nxt;
  logic gate_ok;
  logic in_mode;
  logic suspend_request_n_pin;
  logic nmi_pin;

  function automatic logic quarter_ordered(input logic [7:0] c, input logic [1:0] q);
    quarter_ordered = 1'b0;
    case (q)
      cfg3_pkg::Q_TOP: quarter_ordered = c[cfg3_pkg::BIT_SER_TOP];
      cfg3_pkg::Q_23: quarter_ordered = c[cfg3_pkg::BIT_SER_23];
      cfg3_pkg::Q_12: quarter_ordered = c[cfg3_pkg::BIT_SER_12];
      default: quarter_ordered = 1'b0;
    endcase
  endfunction

  always_comb begin
    pin_s1_nxt = {system_management_mode, ~suspend_request_n, nmi_request};
    pin_s2_nxt = pin_s1_r;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_s1_r <= 3'h0;
      pin_s2_r <= 3'h0;
    end else begin
      pin_s1_r <= pin_s1_nxt;
      pin_s2_r <= pin_s2_nxt;
    end
  end

  assign in_mode = pin_s2_r[2];
  assign suspend_request_n_pin = pin_s2_r[1];
  assign nmi_pin = pin_s2_r[0];

  // ****************************************
  // Register write and read
  // ****************************************
  always_comb begin
    cfg_nxt = cfg_r;
    if (wr && addr == cfg3_pkg::CFG3_INDEX) begin
      if (!cfg_r[cfg3_pkg::BIT_LOCK] || in_mode) begin
        cfg_nxt = wdata & cfg3_pkg::WRITABLE_MASK;
      end else begin
        cfg_nxt = (cfg_r & cfg3_pkg::LOCK_MASK) |
                  (wdata & cfg3_pkg::WRITABLE_MASK & ~cfg3_pkg::LOCK_MASK);
      end
    end
  end

  always_comb begin
    rdata_nxt = 8'h00;
    if (rd && addr == cfg3_pkg::CFG3_INDEX) begin
      rdata_nxt = cfg_r;
    end else if (rd && addr == cfg3_pkg::STATUS_INDEX) begin
      rdata_nxt = {4'h0, in_mode, allowed_r, suspend_request_n_r, nmi_r};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_r <= cfg3_pkg::CFG3_RESET;
      rdata_r <= 8'h00;
    end else begin
      cfg_r <= cfg_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************
  // Block controls
  // ****************************************
  index_gate u_gate (
    .index(ext_index),
    .map_en(cfg_r[cfg3_pkg::BIT_MAP_EN]),
    .allowed(gate_ok)
  );

  always_comb begin
    ordered_nxt = quarter_ordered(cfg_r, access_addr[31:30]);
    allowed_nxt = gate_ok;
    suspend_request_n_nxt = suspend_request_n_pin && (!in_mode || cfg_r[cfg3_pkg::BIT_SUSPEND_REQUEST_N_EN]);
    nmi_nxt = nmi_pin && (!in_mode || cfg_r[cfg3_pkg::BIT_NMI_EN]);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ordered_r <= 1'b0;
      allowed_r <= 1'b0;
      suspend_request_n_r <= 1'b0;
      nmi_r <= 1'b0;
    end else begin
      ordered_r <= ordered_nxt;
      allowed_r <= allowed_nxt;
      suspend_request_n_r <= suspend_request_n_nxt;
      nmi_r <= nmi_nxt;
    end
  end

  assign rdata = rdata_r;
  assign config_control_three = cfg_r;
  assign ordered_access = ordered_r;
  assign ext_index_allowed = allowed_r;
  assign suspend_taken = suspend_request_n_r;
  assign nmi_taken = nmi_r;

  // ****************************************
  // Checks
  // ****************************************
  sequence locked_write_s;
    wr && addr == cfg3_pkg::CFG3_INDEX && cfg_r[cfg3_pkg::BIT_LOCK] && !in_mode;
  endsequence

  a_locked_nmi_hold: assert property (@(posedge clk) disable iff (rst)
    locked_write_s |=> $stable(cfg_r[cfg3_pkg::BIT_NMI_EN]))
    else $error("locked write changed nmi enable");
  a_lock_self_hold: assert property (@(posedge clk) disable iff (rst)
    locked_write_s |=> cfg_r[cfg3_pkg::BIT_LOCK])
    else $error("locked write cleared lock");
  a_reset_clear: assert property (@(posedge clk) rst |=> cfg_r == 8'h00)
    else $error("register not cleared by reset");
  a_top_order: assert property (@(posedge clk) disable iff (rst)
    access_addr[31:30] == 2'h3 |=> ordered_access == $past(cfg_r[7]))
    else $error("top quarter ordering wrong");
  a_q23_order: assert property (@(posedge clk) disable iff (rst)
    access_addr[31:30] == 2'h2 |=> ordered_access == $past(cfg_r[6]))
    else $error("second quarter ordering wrong");
  a_q12_order: assert property (@(posedge clk) disable iff (rst)
    access_addr[31:30] == 2'h1 |=> ordered_access == $past(cfg_r[5]))
    else $error("first quarter ordering wrong");
  a_map_open: assert property (@(posedge clk) disable iff (rst)
    cfg_r[4] |=> ext_index_allowed)
    else $error("map enable did not open index");
  a_map_closed: assert property (@(posedge clk) disable iff (rst)
    !cfg_r[4] && ext_index == 8'hE8 |=> !ext_index_allowed)
    else $error("closed map let index through");
  a_suspend_request_n_mode: assert property (@(posedge clk) disable iff (rst)
    in_mode && !cfg_r[3] |=> !suspend_taken)
    else $error("suspend taken while disabled");
  a_nmi_mode: assert property (@(posedge clk) disable iff (rst)
    in_mode && !cfg_r[1] |=> !nmi_taken)
    else $error("nmi taken while disabled");
  a_spare_zero: assert property (@(posedge clk) disable iff (rst)
    !cfg_r[2])
    else $error("reserved bit set");

  // ****************************************
  // Write path checks
  // ****************************************
  sequence open_write_s;
    wr && addr == cfg3_pkg::CFG3_INDEX && (!cfg_r[cfg3_pkg::BIT_LOCK] || in_mode);
  endsequence

  sequence mode_write_s;
    wr && addr == cfg3_pkg::CFG3_INDEX && in_mode;
  endsequence

  sequence no_write_s;
    !(wr && addr == cfg3_pkg::CFG3_INDEX);
  endsequence

  a_open_write_land: assert property (@(posedge clk) disable iff (rst)
    open_write_s |=> cfg_r == ($past(wdata) & cfg3_pkg::WRITABLE_MASK))
    else $error("unlocked write did not land");
  a_mode_nmi_write: assert property (@(posedge clk) disable iff (rst)
    mode_write_s |=> cfg_r[cfg3_pkg::BIT_NMI_EN] == $past(wdata[cfg3_pkg::BIT_NMI_EN]))
    else $error("mode write missed nmi enable");
  a_mode_suspend_request_n_write: assert property (@(posedge clk) disable iff (rst)
    mode_write_s |=> cfg_r[cfg3_pkg::BIT_SUSPEND_REQUEST_N_EN] == $past(wdata[cfg3_pkg::BIT_SUSPEND_REQUEST_N_EN]))
    else $error("mode write missed suspend enable");
  a_mode_lock_write: assert property (@(posedge clk) disable iff (rst)
    mode_write_s |=> cfg_r[cfg3_pkg::BIT_LOCK] == $past(wdata[cfg3_pkg::BIT_LOCK]))
    else $error("mode write missed lock");
  a_locked_free_bits: assert property (@(posedge clk) disable iff (rst)
    locked_write_s |=> (cfg_r & ~cfg3_pkg::LOCK_MASK) ==
      ($past(wdata) & cfg3_pkg::WRITABLE_MASK & ~cfg3_pkg::LOCK_MASK))
    else $error("locked write lost free bits");
  a_locked_suspend_request_n_hold: assert property (@(posedge clk) disable iff (rst)
    locked_write_s |=> $stable(cfg_r[cfg3_pkg::BIT_SUSPEND_REQUEST_N_EN]))
    else $error("locked write changed suspend enable");
  a_idle_cfg_hold: assert property (@(posedge clk) disable iff (rst)
    no_write_s |=> $stable(cfg_r))
    else $error("register changed without write");

  // ****************************************
  // Read path checks
  // ****************************************
  sequence cfg_read_s;
    rd && addr == cfg3_pkg::CFG3_INDEX;
  endsequence

  sequence status_read_s;
    rd && addr == cfg3_pkg::STATUS_INDEX;
  endsequence

  a_read_spare_zero: assert property (@(posedge clk) disable iff (rst)
    cfg_read_s |=> !rdata[cfg3_pkg::BIT_SPARE])
    else $error("reserved bit read as one");
  a_status_mode: assert property (@(posedge clk) disable iff (rst)
    status_read_s |=> rdata[3] == $past(in_mode))
    else $error("status mode bit wrong");
  a_status_map: assert property (@(posedge clk) disable iff (rst)
    status_read_s |=> rdata[2] == $past(ext_index_allowed))
    else $error("status index bit wrong");
  a_status_suspend_request_n: assert property (@(posedge clk) disable iff (rst)
    status_read_s |=> rdata[1] == $past(suspend_taken))
    else $error("status suspend bit wrong");
  a_status_nmi: assert property (@(posedge clk) disable iff (rst)
    status_read_s |=> rdata[0] == $past(nmi_taken))
    else $error("status nmi bit wrong");

  // ****************************************
  // Control output checks
  // ****************************************
  function automatic logic open_index(input logic [7:0] idx);
    open_index = idx inside {[cfg3_pkg::OPEN_A_LO:cfg3_pkg::OPEN_A_HI],
      [cfg3_pkg::OPEN_B_LO:cfg3_pkg::OPEN_B_HI], [cfg3_pkg::OPEN_C_LO:cfg3_pkg::OPEN_C_HI]};
  endfunction

  sequence closed_open_s;
    !cfg_r[cfg3_pkg::BIT_MAP_EN] && open_index(ext_index);
  endsequence

  sequence closed_shut_s;
    !cfg_r[cfg3_pkg::BIT_MAP_EN] && !open_index(ext_index);
  endsequence

  a_reset_outputs: assert property (@(posedge clk)
    rst |=> rdata == 8'h00 && !ordered_access && !ext_index_allowed &&
      !suspend_taken && !nmi_taken)
    else $error("outputs not cleared by reset");
  a_low_quarter_free: assert property (@(posedge clk) disable iff (rst)
    access_addr[31:30] == 2'h0 |=> !ordered_access)
    else $error("lowest quarter ordered");
  a_closed_open_pass: assert property (@(posedge clk) disable iff (rst)
    closed_open_s |=> ext_index_allowed)
    else $error("closed map blocked open index");
  a_closed_shut_block: assert property (@(posedge clk) disable iff (rst)
    closed_shut_s |=> !ext_index_allowed)
    else $error("closed map passed gated index");
  a_suspend_request_n_mode_pass: assert property (@(posedge clk) disable iff (rst)
    in_mode && cfg_r[3] && suspend_request_n_pin |=> suspend_taken)
    else $error("enabled suspend not taken");
  a_suspend_request_n_idle: assert property (@(posedge clk) disable iff (rst)
    !suspend_request_n_pin |=> !suspend_taken)
    else $error("suspend taken without request");
  a_nmi_mode_pass: assert property (@(posedge clk) disable iff (rst)
    in_mode && cfg_r[1] && nmi_pin |=> nmi_taken)
    else $error("enabled nmi not taken");
  a_nmi_idle: assert property (@(posedge clk) disable iff (rst)
    !nmi_pin |=> !nmi_taken)
    else $error("nmi taken without request");
endmodule

// ===== sim/tb_mgmt_mode_config_control.sv
`timescale 1ns/10ps
`define CHK(what, exp, got) begin checked++; if ((got) !== (exp)) begin fail_count++; \
  $display("unexpected %s expected %h seen %h", what, exp, got); end end
module tb_mgmt_mode_config_control;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic mgmt_mode = 1'b0;
  logic suspend_request_n_n = 1'b1;
  logic nmi_req = 1'b0;
  logic [31:0] access_addr = 32'h00000000;
  logic [7:0] ext_index = 8'h00;
  logic [7:0] rdata;
  logic [7:0] ccr;
  logic ordered;
  logic ext_ok;
  logic suspend_request_n_t;
  logic nmi_t;
  int fail_count = 0;
  int checked = 0;
  logic [7:0] idx_list [12] = '{8'hC0, 8'hC1, 8'hC2, 8'hC3, 8'hC4, 8'hCC, 8'hCD, 8'hCF, 8'hD0,
                                8'hE8, 8'hFD, 8'hFE};
  logic [11:0] open_mask = 12'h731;
  mgmt_mode_config_control i_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .system_management_mode(mgmt_mode), .suspend_request_n(suspend_request_n_n),
    .nmi_request(nmi_req), .access_addr(access_addr), .ext_index(ext_index),
    .config_control_three(ccr), .ordered_access(ordered), .ext_index_allowed(ext_ok),
    .suspend_taken(suspend_request_n_t), .nmi_taken(nmi_t));
  always #25 clk = ~clk;
  // ****************************************
  // Access tasks
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK("rdata", exp, rdata)
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    final_report();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    cyc(1);
    reg_rd(8'hC3, 8'h00);
    reg_wr(8'h10, 8'hFF);
    `CHK("unmapped write", 8'h00, ccr)
    reg_rd(8'h10, 8'h00);
    reg_wr(8'hC3, 8'hFF);
    `CHK("reserved bit", 8'hFB, ccr)
    reg_rd(8'hC3, 8'hFB);
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      ext_index <= idx_list[i];
      cyc(2);
      `CHK("map open", 1'h1, ext_ok)
    end
    reg_wr(8'hC3, 8'h00);
    `CHK("lock kept", 8'h0B, ccr)
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      ext_index <= idx_list[i];
      cyc(2);
      `CHK("map closed", open_mask[11 - i], ext_ok)
    end
    for (int b = 5; b < 8; b++) begin
      reg_wr(8'hC3, 8'h01 << b);
      for (int q = 0; q < 4; q++) begin
        @(posedge clk);
        access_addr <= {q[1:0], 30'h0};
        cyc(2);
        `CHK("ordering", (q > 0) && (4 + q == b), ordered)
      end
    end
    reg_wr(8'hC3, 8'h0B);
    reg_wr(8'hC3, 8'hF4);
    `CHK("locked write", 8'hFB, ccr)
    reg_wr(8'hC3, 8'h00);
    `CHK("locked clear", 8'h0B, ccr)
    @(posedge clk);
    mgmt_mode <= 1'b1;
    suspend_request_n_n <= 1'b0;
    nmi_req <= 1'b1;
    cyc(4);
    `CHK("suspend on", 1'h1, suspend_request_n_t)
    `CHK("nmi on", 1'h1, nmi_t)
    reg_rd(8'hC4, 8'h0F);
    reg_wr(8'hC3, 8'h00);
    `CHK("mode write", 8'h00, ccr)
    cyc(4);
    `CHK("suspend off", 1'h0, suspend_request_n_t)
    `CHK("nmi off", 1'h0, nmi_t)
    @(posedge clk);
    mgmt_mode <= 1'b0;
    cyc(4);
    `CHK("suspend outside", 1'h1, suspend_request_n_t)
    `CHK("nmi outside", 1'h1, nmi_t)
    reg_wr(8'hC3, 8'hF0);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    cyc(1);
    `CHK("reset", 8'h00, ccr)
    `CHK("reset suspend", 1'h0, suspend_request_n_t)
    final_report();
  end
endmodule
